// file: core/spi_irq_flags_data_port.v
// spi interrupt enable, flag and data-port logic with a compact mode-0 byte shifter
`timescale 1ns/10ps
// How it works
// - buffered mode: rx-done enable bit 7 gates rx-done flag; reads zero in normal mode
// - buffered mode: tx-done enable bit 6 gates tx-done flag; reads zero in normal mode
// - buffered mode: buffer-empty enable bit 5 gates buffer-empty flag; zero in normal mode
// - buffered mode: select-trigger enable bit 4 gates its flag; zero in normal mode
// - normal mode: general enable bit 0 lets byte-complete flag raise the interrupt
// - request is high while a flag and its enable are set, until flag clears
// - normal mode: byte-complete flag sets when a full byte has shifted
// - normal mode: byte-complete also sets when select input pulled low in host mode, unless select disabled
// - byte-complete clears on vector taken, or flag read then data-port access
// - write collision sets on data write mid-byte; clears by flag read then data access
// - rx-done flag follows unread receive data; writing one flushes it
// - tx-done sets when shifter empties with no byte waiting; cleared by writing one
// - buffer-empty reads one when transmit buffer empty; data write clears it
// - select-trigger sets on forced fall to client, unless select disabled; write one clears
// - overflow bit 0 sets when both receive entries full and a third byte completes
// - with no transmit data pending, overflow waits for the next transfer start
// - overflow clears on data-port read or by writing one
// - data write starts transfer as host; as client it only stages the byte
// - normal mode: writes load shifter, reads return receive data register
// - buffered mode: writes go to tx buffer; reads pop the two-entry receive buffer
// - select input low in host mode clears host bit unless select disabled; software must set it again
// - buffered mode offers two receive entries and one transmit entry
`include "spi_irq_defines.vh"

module spi_irq_flags_data_port (
	input wire clk_sys,
	input wire sys_rst,
	input wire [2:0] regAddr,
	input wire [7:0] regWrData,
	input wire regWr,
	input wire regRd,
	output reg [7:0] regRdData,
	output reg irqReq,
	input wire irqAck,
	input wire sckIn,
	output reg sckOut,
	output reg sckOe,
	input wire sdiIn,
	output reg sdoOut,
	output reg sdoOe,
	input wire selectN
);

	localparam integer HALF_CYC_M1 = `SCK_HALF_CYC - 1;
	localparam [3:0] HALF_M1 = HALF_CYC_M1[3:0];

	// ------------------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------------------
	reg [2:0] sckSync;
	reg [1:0] sdiSync;
	reg [1:0] selSync;

	// first stage of each chain is only read by the second
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			sckSync <= 3'h0;
			sdiSync <= 2'h0;
			selSync <= 2'h3;
		end else begin
			sckSync <= {sckSync[1:0], sckIn};
			sdiSync <= {sdiSync[0], sdiIn};
			selSync <= {selSync[0], selectN};
		end
	end

	// ------------------------------------------------------------------------
	// state declarations
	// ------------------------------------------------------------------------
	reg enable;
	reg selIsInput;
	reg hostMode;
	reg bufferedModeEn;
	reg selectDisable;
	reg rxDoneIrqEn;
	reg txDoneIrqEn;
	reg txBufEmptyIrqEn;
	reg selectTriggerIrqEn;
	reg generalIrqEn;
	reg byteDoneFlag;
	reg writeCollisionFlag;
	reg armByteDone;
	reg armCollision;
	reg txDoneFlag;
	reg selectTriggerFlag;
	reg rxOverflowFlag;
	reg ovfPending;
	reg [7:0] txBuf;
	reg txBufValid;
	reg [7:0] rxDataReg;
	reg [7:0] rxBuf0;
	reg [7:0] rxBuf1;
	reg [1:0] rxCount;
	reg [7:0] shiftReg;
	reg sampleBit;
	reg [3:0] bitCnt;
	reg [3:0] divCnt;
	reg hostBusy;

	// ------------------------------------------------------------------------
	// register port decode
	// ------------------------------------------------------------------------
	wire wrCtrlA = regWr && (regAddr == `OFS_CTRL_A);
	wire wrCtrlB = regWr && (regAddr == `OFS_CTRL_B);
	wire wrIrqEn = regWr && (regAddr == `OFS_IRQ_EN);
	wire wrFlags = regWr && (regAddr == `OFS_IRQ_FLAGS);
	wire wrData = regWr && (regAddr == `OFS_DATA);
	wire rdFlags = regRd && (regAddr == `OFS_IRQ_FLAGS);
	wire rdData = regRd && (regAddr == `OFS_DATA);
	wire dataAccess = wrData || rdData;

	// write-one-to-clear strobes only act in buffered mode
	wire clrRxDone = wrFlags && bufferedModeEn && regWrData[`FB_RX_DONE];
	wire clrTxDone = wrFlags && bufferedModeEn && regWrData[`FB_TX_DONE];
	wire clrSelTrig = wrFlags && bufferedModeEn && regWrData[`FB_SELECT_TRIGGER];
	wire clrOverflow = wrFlags && bufferedModeEn && regWrData[`FB_RX_OVERFLOW];

	// ------------------------------------------------------------------------
	// shifter event terms
	// ------------------------------------------------------------------------
	wire selLow = ~selSync[1];
	wire sckRise = sckSync[1] & ~sckSync[2];
	wire sckFall = ~sckSync[1] & sckSync[2];
	wire clientActive = enable & ~hostMode & selLow;
	wire hostTick = hostBusy & hostMode & (divCnt == HALF_M1);
	wire shiftRise = (hostTick & ~sckOut) | (clientActive & sckRise);
	wire shiftFall = (hostTick & sckOut) | (clientActive & sckFall);
	wire byteDone = shiftFall & (bitCnt == `BITS_PER_BYTE_M1);
	wire [7:0] rxByte = {shiftReg[6:0], sampleBit};
	wire engineBusy = hostBusy | (bitCnt != `RST_CNT4);
	wire transferStart = shiftRise & (bitCnt == `RST_CNT4);

	// select pulled low while host: fault only when pin is an input and not disabled
	wire selFault = enable & hostMode & selIsInput & ~selectDisable & selLow;

	// client deselected mid-byte drops the partial byte
	wire clientAbort = ~hostMode & ~selLow & (bitCnt != `RST_CNT4);

	// normal-mode write: collision if a byte is still moving
	wire collide = wrData & ~bufferedModeEn & engineBusy;
	wire loadDirect = wrData & ~bufferedModeEn & ~engineBusy;
	wire loadFromBuf = bufferedModeEn & txBufValid & ~engineBusy & enable & ~selFault;
	wire loadShift = loadDirect | loadFromBuf;
	wire [7:0] loadValue = bufferedModeEn ? txBuf : regWrData;

	// receive buffer occupancy after a possible pop in this cycle
	wire rxPop = rdData & bufferedModeEn & (rxCount != `RST_CNT2);
	wire [1:0] rxAfterPop = rxPop ? (rxCount - `RX_ONE) : (clrRxDone ? `RST_CNT2 : rxCount);
	wire rxPush = byteDone & bufferedModeEn;
	wire rxLost = rxPush & (rxAfterPop == `RX_DEPTH);

	// ------------------------------------------------------------------------
	// control and enable registers
	// ------------------------------------------------------------------------
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			enable <= 1'b0;
			selIsInput <= 1'b0;
			hostMode <= 1'b0;
			bufferedModeEn <= 1'b0;
			selectDisable <= 1'b0;
			rxDoneIrqEn <= 1'b0;
			txDoneIrqEn <= 1'b0;
			txBufEmptyIrqEn <= 1'b0;
			selectTriggerIrqEn <= 1'b0;
			generalIrqEn <= 1'b0;
		end else begin
			if (wrCtrlA) begin
				enable <= regWrData[`CA_ENABLE];
				selIsInput <= regWrData[`CA_SEL_IS_INPUT];
			end
			// the fault wins over a same-cycle write; software rewrites the bit to resume
			if (selFault) begin
				hostMode <= 1'b0;
			end else if (wrCtrlA) begin
				hostMode <= regWrData[`CA_HOST_MODE];
			end
			if (wrCtrlB) begin
				bufferedModeEn <= regWrData[`CB_BUFFERED_MODE_EN];
				selectDisable <= regWrData[`CB_SELECT_DISABLE];
			end
			if (wrIrqEn) begin
				rxDoneIrqEn <= regWrData[`IE_RX_DONE];
				txDoneIrqEn <= regWrData[`IE_TX_DONE];
				txBufEmptyIrqEn <= regWrData[`IE_TX_BUF_EMPTY];
				selectTriggerIrqEn <= regWrData[`IE_SELECT_TRIGGER];
				generalIrqEn <= regWrData[`IE_GENERAL];
			end
		end
	end

	// ------------------------------------------------------------------------
	// shift engine: mode 0, msb first, sample on rise, shift on fall
	// ------------------------------------------------------------------------
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			shiftReg <= `RST_BYTE;
			sampleBit <= 1'b0;
			bitCnt <= `RST_CNT4;
			divCnt <= `RST_CNT4;
			hostBusy <= 1'b0;
			sckOut <= 1'b0;
		end else if (selFault || clientAbort || !enable) begin
			// abort leaves the shifter contents but stops the byte
			bitCnt <= `RST_CNT4;
			divCnt <= `RST_CNT4;
			hostBusy <= 1'b0;
			sckOut <= 1'b0;
		end else begin
			if (loadShift) begin
				shiftReg <= loadValue;
				hostBusy <= hostMode;
				divCnt <= `RST_CNT4;
			end else if (hostBusy) begin
				divCnt <= hostTick ? `RST_CNT4 : divCnt + 4'h1;
				if (hostTick) begin
					sckOut <= ~sckOut;
				end
			end
			if (shiftRise) begin
				sampleBit <= sdiSync[1];
			end
			if (shiftFall) begin
				shiftReg <= rxByte;
				bitCnt <= byteDone ? `RST_CNT4 : bitCnt + 4'h1;
				if (byteDone) begin
					hostBusy <= 1'b0;
				end
			end
		end
	end

	// ------------------------------------------------------------------------
	// transmit buffer and receive path
	// ------------------------------------------------------------------------
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			txBuf <= `RST_BYTE;
			txBufValid <= 1'b0;
			rxDataReg <= `RST_BYTE;
			rxBuf0 <= `RST_BYTE;
			rxBuf1 <= `RST_BYTE;
			rxCount <= `RST_CNT2;
		end else begin
			// a write in the cycle the old byte moves out keeps the buffer full
			if (wrData && bufferedModeEn) begin
				txBuf <= regWrData;
				txBufValid <= 1'b1;
			end else if (loadFromBuf) begin
				txBufValid <= 1'b0;
			end
			if (byteDone && !bufferedModeEn) begin
				rxDataReg <= rxByte;
			end
			// pop moves the second entry forward before any push lands
			if (rxPop) begin
				rxBuf0 <= rxBuf1;
			end
			if (rxPush && (rxAfterPop == `RST_CNT2)) begin
				rxBuf0 <= rxByte;
			end
			if (rxPush && (rxAfterPop == `RX_ONE)) begin
				rxBuf1 <= rxByte;
			end
			rxCount <= (rxPush && !rxLost) ? rxAfterPop + `RX_ONE : rxAfterPop;
		end
	end

	// ------------------------------------------------------------------------
	// event flags: a set in the same cycle as a clear always wins
	// ------------------------------------------------------------------------
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			byteDoneFlag <= 1'b0;
			writeCollisionFlag <= 1'b0;
			armByteDone <= 1'b0;
			armCollision <= 1'b0;
			txDoneFlag <= 1'b0;
			selectTriggerFlag <= 1'b0;
			rxOverflowFlag <= 1'b0;
			ovfPending <= 1'b0;
		end else begin
			// flag read arms the clear; the next data access performs it
			if (rdFlags && !bufferedModeEn) begin
				armByteDone <= byteDoneFlag;
				armCollision <= writeCollisionFlag;
			end else if (dataAccess) begin
				armByteDone <= 1'b0;
				armCollision <= 1'b0;
			end
			if ((byteDone || selFault) && !bufferedModeEn) begin
				byteDoneFlag <= 1'b1;
			end else if (irqAck || (dataAccess && armByteDone)) begin
				byteDoneFlag <= 1'b0;
			end
			if (collide) begin
				writeCollisionFlag <= 1'b1;
			end else if (dataAccess && armCollision) begin
				writeCollisionFlag <= 1'b0;
			end
			// a byte that finished with nothing queued ends the stream
			if (byteDone && bufferedModeEn && !txBufValid) begin
				txDoneFlag <= 1'b1;
			end else if (clrTxDone) begin
				txDoneFlag <= 1'b0;
			end
			if (selFault && bufferedModeEn) begin
				selectTriggerFlag <= 1'b1;
			end else if (clrSelTrig) begin
				selectTriggerFlag <= 1'b0;
			end
			// without queued data the loss is only reported once traffic resumes
			if (rxLost && !txBufValid) begin
				ovfPending <= 1'b1;
			end else if (transferStart || !bufferedModeEn) begin
				ovfPending <= 1'b0;
			end
			if ((rxLost && txBufValid) || (ovfPending && transferStart)) begin
				rxOverflowFlag <= 1'b1;
			end else if (rxPop || (rdData && bufferedModeEn) || clrOverflow) begin
				rxOverflowFlag <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------------
	// read views: enables and flags depend on buffered mode
	// ------------------------------------------------------------------------
	wire rxDoneFlag = (rxCount != `RST_CNT2);
	wire txBufEmptyFlag = ~txBufValid;
	wire [7:0] irqEnView = {rxDoneIrqEn & bufferedModeEn, txDoneIrqEn & bufferedModeEn,
		txBufEmptyIrqEn & bufferedModeEn, selectTriggerIrqEn & bufferedModeEn,
		3'h0, generalIrqEn};
	wire [7:0] flagsNormal = {byteDoneFlag, writeCollisionFlag, 6'h00};
	wire [7:0] flagsBuffered = {rxDoneFlag, txDoneFlag, txBufEmptyFlag, selectTriggerFlag,
		3'h0, rxOverflowFlag};

	// merged request; only enables visible in the current mode count
	wire nextIrq = bufferedModeEn ?
		((rxDoneFlag & irqEnView[`IE_RX_DONE]) | (txDoneFlag & irqEnView[`IE_TX_DONE]) |
		(txBufEmptyFlag & irqEnView[`IE_TX_BUF_EMPTY]) |
		(selectTriggerFlag & irqEnView[`IE_SELECT_TRIGGER])) :
		(byteDoneFlag & generalIrqEn);

	reg [7:0] next_rdData;

	// read mux for the one-cycle-late read data
	always @* begin
		next_rdData = `RST_BYTE;
		case (regAddr)
			`OFS_CTRL_A: begin
				next_rdData = {2'h0, hostMode, 1'b0, selIsInput, 2'h0, enable};
			end
			`OFS_CTRL_B: begin
				next_rdData = {bufferedModeEn, 4'h0, selectDisable, 2'h0};
			end
			`OFS_IRQ_EN: begin
				next_rdData = irqEnView;
			end
			`OFS_IRQ_FLAGS: begin
				next_rdData = bufferedModeEn ? flagsBuffered : flagsNormal;
			end
			`OFS_DATA: begin
				next_rdData = bufferedModeEn ? rxBuf0 : rxDataReg;
			end
			default: begin
				next_rdData = `RST_BYTE;
			end
		endcase
	end

	// ------------------------------------------------------------------------
	// registered outputs
	// ------------------------------------------------------------------------
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			regRdData <= `RST_BYTE;
			irqReq <= 1'b0;
			sckOe <= 1'b0;
			sdoOut <= 1'b0;
			sdoOe <= 1'b0;
		end else begin
			regRdData <= regRd ? next_rdData : `RST_BYTE; // valid only in the cycle after a read
			irqReq <= nextIrq;
			sckOe <= enable & hostMode;
			sdoOut <= shiftReg[7];
			sdoOe <= enable & (hostMode | selLow); // client drives only while selected
		end
	end

endmodule

// file: include/spi_irq_defines.vh
// register map, field positions, reset values and timing constants of the spi flag and data-port block
`ifndef SPI_IRQ_DEFINES_VH
`define SPI_IRQ_DEFINES_VH

// ----------------------------------------------------------------------------
// register offsets (3-bit port address)
// ----------------------------------------------------------------------------
`define OFS_CTRL_A 3'h0
`define OFS_CTRL_B 3'h1
`define OFS_IRQ_EN 3'h2
`define OFS_IRQ_FLAGS 3'h3
`define OFS_DATA 3'h4

// ----------------------------------------------------------------------------
// control bits
// ----------------------------------------------------------------------------
`define CA_ENABLE 0
`define CA_SEL_IS_INPUT 3
`define CA_HOST_MODE 5
`define CB_SELECT_DISABLE 2
`define CB_BUFFERED_MODE_EN 7

// ----------------------------------------------------------------------------
// interrupt enable bits
// ----------------------------------------------------------------------------
`define IE_RX_DONE 7
`define IE_TX_DONE 6
`define IE_TX_BUF_EMPTY 5
`define IE_SELECT_TRIGGER 4
`define IE_GENERAL 0

// ----------------------------------------------------------------------------
// flag bits, normal and buffered layouts
// ----------------------------------------------------------------------------
`define FN_BYTE_DONE 7
`define FN_WRITE_COLLISION 6
`define FB_RX_DONE 7
`define FB_TX_DONE 6
`define FB_TX_BUF_EMPTY 5
`define FB_SELECT_TRIGGER 4
`define FB_RX_OVERFLOW 0

// ----------------------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------------------
`define RST_BYTE 8'h00
`define RST_CNT4 4'h0
`define RST_CNT2 2'h0
`define BITS_PER_BYTE_M1 4'h7
`define RX_DEPTH 2'h2
`define RX_ONE 2'h1

// ----------------------------------------------------------------------------
// timing: host serial clock half period
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS 40
`define SCK_HALF_NS 160
`define SCK_HALF_CYC ((`SCK_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// file: testbench/spi_irq_flags_data_port_asserts.sv
// checker for the spi flag and data-port block, bound to its ports
`timescale 1ns/10ps
`include "spi_irq_defines.vh"
module spi_irq_flags_data_port_asserts (
	input wire clk_sys,
	input wire sys_rst,
	input wire [2:0] regAddr,
	input wire [7:0] regWrData,
	input wire regWr,
	input wire regRd,
	input wire [7:0] regRdData,
	input wire irqReq,
	input wire sckOut,
	input wire sckOe,
	input wire sdoOe
);
	// ----------------------------------------
	// shadow of the control bits software wrote
	// ----------------------------------------
	logic bufMode;
	logic enBit;
	logic [7:0] ieShadow;
	logic [7:0] ieView;
	// the upper enables only count in buffered mode, so mask them as the block must
	assign ieView = bufMode ? {ieShadow[7:4], 3'h0, ieShadow[0]} : {7'h00, ieShadow[0]};
	// the host bit can be cleared by the block, so only the enable bit is mirrored
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			bufMode <= 1'b0;
			enBit <= 1'b0;
			ieShadow <= 8'h00;
		end else if (regWr) begin
			if (regAddr == `OFS_CTRL_A)
				enBit <= regWrData[`CA_ENABLE];
			if (regAddr == `OFS_CTRL_B)
				bufMode <= regWrData[`CB_BUFFERED_MODE_EN];
			if (regAddr == `OFS_IRQ_EN)
				ieShadow <= regWrData;
		end
	end
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);
	AST_READ_IDLE_ZERO: assert property (!$past(regRd) |-> regRdData == 8'h00)
		else $error("read data not idle");
	AST_UNMAPPED_ZERO: assert property (regRd && regAddr > `OFS_DATA |=> regRdData == 8'h00)
		else $error("unmapped read not zero");
	AST_ENABLE_READBACK: assert property (regRd && regAddr == `OFS_IRQ_EN |=> regRdData == $past(ieView))
		else $error("enable readback wrong");
	AST_NO_ENABLE_NO_IRQ: assert property ((ieView == 8'h00) [*2] |-> !irqReq)
		else $error("request without enable");
	AST_IRQ_HAS_CAUSE: assert property ($rose(irqReq) |-> $past(ieView) != 8'h00)
		else $error("request rose without enable");
	AST_SCK_OE_NEEDS_ENABLE: assert property ((!enBit) [*2] |-> !sckOe)
		else $error("clock driven while disabled");
	AST_SDO_OE_NEEDS_ENABLE: assert property ((!enBit) [*2] |-> !sdoOe)
		else $error("data driven while disabled");
	AST_SCK_HIGH_TIME: assert property ($rose(sckOut) |-> sckOut [*4] ##1 !sckOut)
		else $error("clock high time wrong");
	AST_SCK_ONLY_DRIVEN: assert property ($rose(sckOut) |-> sckOe)
		else $error("clock toggles undriven");
endmodule
bind spi_irq_flags_data_port spi_irq_flags_data_port_asserts spi_irq_flags_data_port_asserts_i (.clk_sys,
	.sys_rst, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .irqReq, .sckOut, .sckOe, .sdoOe);

// file: testbench/spi_far_model.sv
// far-side spi party: answers as a client, or clocks the block as a host
`timescale 1ns/10ps
module spi_far_model (
	input wire logic sckOut,
	input wire logic sdoOut,
	output logic sckIn,
	output logic sdiIn,
	output logic selectN
);
	logic [7:0] reply;
	logic [7:0] got;
	int cnt = 8;
	int frames = 0;
	// idle: clock still low, select pulled up
	initial begin
		sckIn = 1'b0;
		sdiIn = 1'b0;
		selectN = 1'b1;
		got = 8'h00;
	end
	// take the block's bit on its sampling edge
	always @(posedge sckOut) got = {got[6:0], sdoOut};
	// next reply bit on the falling edge; a released line toggles so it never looks valid
	always @(negedge sckOut) begin
		cnt = cnt + 1;
		if (cnt < 8)
			sdiIn <= reply[7 - cnt];
		else
			sdiIn <= ~sdiIn;
		if (cnt == 8)
			frames = frames + 1;
	end
	task load(input logic [7:0] b);
		reply = b;
		cnt = 0;
		sdiIn <= b[7];
	endtask
	task fault(input int t);
		selectN <= 1'b0;
		#(t);
		selectN <= 1'b1;
	endtask
	// one mode-0 byte at a 320 ns link period, msb first
	// starts off the system clock edge so the block's shifted bit has settled before each rise
	task drive(input logic [7:0] b);
		#10;
		selectN <= 1'b0;
		for (int i = 7; i >= 0; i--) begin
			sdiIn <= b[i];
			#160;
			sckIn <= 1'b1;
			got = {got[6:0], sdoOut};
			#160;
			sckIn <= 1'b0;
		end
		#160;
		selectN <= 1'b1;
		sdiIn <= ~sdiIn;
		frames = frames + 1;
	endtask
endmodule

// file: testbench/testbench.sv
// self-checking bench for the spi flag and data-port block
`timescale 1ns/10ps
`include "spi_irq_defines.vh"
module testbench;
	logic clk_sys, sys_rst, regWr, regRd, irqAck, rdPend;
	logic [2:0] regAddr;
	logic [7:0] regWrData, tx, rx;
	logic [7:0] b [4];
	logic [7:0] expQ [$];
	wire [7:0] regRdData;
	wire irqReq, sckOut, sckOe, sdoOut, sdoOe, sckIn, sdiIn, selectN;
	int errors = 0;
	int checked = 0;
	int cyc = 0;
	spi_irq_flags_data_port spi_irq_flags_data_port_i (.clk_sys, .sys_rst, .regAddr, .regWrData, .regWr,
		.regRd, .regRdData, .irqReq, .irqAck, .sckIn, .sckOut, .sckOe, .sdiIn, .sdoOut, .sdoOe, .selectN);
	spi_far_model spi_far_model_i (.sckOut, .sdoOut, .sckIn, .sdiIn, .selectN);
	// 25 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	task complete_run;
		$display("comparisons %0d, mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task check(input logic [7:0] seen, input logic [7:0] expv);
		checked++;
		if (seen !== expv) begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, expv);
		end
	endtask
	// bus tasks start just after a rising edge and end on one, with a gap cycle
	task wr(input logic [2:0] a, input logic [7:0] d);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge clk_sys);
		regWr <= 1'b0;
		@(posedge clk_sys);
	endtask
	task rd(input logic [2:0] a, input logic [7:0] e);
		expQ.push_back(e);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk_sys);
		regRd <= 1'b0;
		@(posedge clk_sys);
	endtask
	task tick(input int c);
		repeat (c) @(posedge clk_sys);
	endtask
	task irqIs(input logic e);
		@(negedge clk_sys);
		check({7'h00, irqReq}, {7'h00, e});
		@(posedge clk_sys);
	endtask
	task waitIrq;
		for (int k = 0; k < 300 && irqReq !== 1'b1; k++) @(negedge clk_sys);
		check({7'h00, irqReq}, 8'h01);
		@(posedge clk_sys);
	endtask
	task waitFrame;
		int f;
		f = spi_far_model_i.frames;
		for (int k = 0; k < 300 && spi_far_model_i.frames == f; k++) @(posedge clk_sys);
		check(8'(spi_far_model_i.frames - f), 8'h01);
		tick(6);
	endtask
	// read answers arrive one cycle after the strobe; the oldest note is compared then
	always @(posedge clk_sys) rdPend <= regRd;
	always @(negedge clk_sys) if (rdPend === 1'b1) check(regRdData, expQ.pop_front());
	// hang guard
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			errors++;
			complete_run();
		end
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		sys_rst = 1'b1;
		regWr = 1'b0;
		regRd = 1'b0;
		irqAck = 1'b0;
		regAddr = 3'h0;
		regWrData = 8'h00;
		tx = 8'($urandom(32'h400cb488));
		tick(3);
		sys_rst <= 1'b0;
		tick(1);
		rd(`OFS_IRQ_EN, 8'h00);
		rd(`OFS_IRQ_FLAGS, 8'h00);
		rd(`OFS_DATA, 8'h00);
		rd(3'h6, 8'h00);
		tx = 8'($urandom);
		wr(`OFS_IRQ_EN, tx | 8'hf0);
		rd(`OFS_IRQ_EN, {7'h00, tx[0]});
		wr(`OFS_CTRL_A, 8'h29);
		wr(`OFS_IRQ_EN, 8'h01);
		// normal host bytes: collision on the first, vector acknowledge on the second
		for (int i = 0; i < 2; i++) begin
			rx = 8'($urandom);
			tx = 8'($urandom);
			spi_far_model_i.load(rx);
			wr(`OFS_DATA, tx);
			if (i == 0) wr(`OFS_DATA, ~tx);
			waitIrq();
			check(spi_far_model_i.got, tx);
			if (i == 0) begin
				rd(`OFS_IRQ_FLAGS, 8'hc0);
			end else begin
				irqAck <= 1'b1;
				tick(1);
				irqAck <= 1'b0;
				tick(2);
			end
			rd(`OFS_DATA, rx);
			irqIs(1'b0);
			rd(`OFS_IRQ_FLAGS, 8'h00);
		end
		spi_far_model_i.fault(400);
		tick(2);
		rd(`OFS_CTRL_A, 8'h09);
		rd(`OFS_IRQ_FLAGS, 8'h80);
		rd(`OFS_DATA, rx);
		rd(`OFS_IRQ_FLAGS, 8'h00);
		// buffered host byte, each buffered enable in turn
		wr(`OFS_IRQ_EN, 8'h00);
		wr(`OFS_CTRL_B, 8'h80);
		wr(`OFS_CTRL_A, 8'h29);
		rd(`OFS_IRQ_FLAGS, 8'h20);
		rx = 8'($urandom);
		tx = 8'($urandom);
		spi_far_model_i.load(rx);
		wr(`OFS_DATA, tx);
		waitFrame();
		check(spi_far_model_i.got, tx);
		rd(`OFS_IRQ_FLAGS, 8'he0);
		for (int i = 7; i >= 4; i--) begin
			wr(`OFS_IRQ_EN, 8'h01 << i);
			irqIs(i != 4);
		end
		wr(`OFS_IRQ_EN, 8'h00);
		rd(`OFS_DATA, rx);
		rd(`OFS_IRQ_FLAGS, 8'h60);
		wr(`OFS_IRQ_FLAGS, 8'h40);
		rd(`OFS_IRQ_FLAGS, 8'h20);
		// fill the receive side past its two entries
		for (int i = 0; i < 4; i++) begin
			b[i] = 8'($urandom);
			tx = 8'($urandom);
			spi_far_model_i.load(b[i]);
			wr(`OFS_DATA, tx);
			waitFrame();
			if (i == 2) rd(`OFS_IRQ_FLAGS, 8'he0);
		end
		rd(`OFS_IRQ_FLAGS, 8'he1);
		rd(`OFS_DATA, b[0]);
		rd(`OFS_IRQ_FLAGS, 8'he0);
		rd(`OFS_DATA, b[1]);
		wr(`OFS_IRQ_FLAGS, 8'hd1);
		rd(`OFS_IRQ_FLAGS, 8'h20);
		// select pulled low as host, with and without select disable
		for (int i = 0; i < 2; i++) begin
			wr(`OFS_CTRL_B, i ? 8'h80 : 8'h84);
			spi_far_model_i.fault(400);
			tick(2);
			rd(`OFS_CTRL_A, i ? 8'h09 : 8'h29);
			rd(`OFS_IRQ_FLAGS, i ? 8'h30 : 8'h20);
		end
		wr(`OFS_IRQ_FLAGS, 8'h10);
		rd(`OFS_IRQ_FLAGS, 8'h20);
		// client: a write only stages the byte until the far host clocks it
		tx = 8'($urandom);
		rx = 8'($urandom);
		wr(`OFS_DATA, tx);
		tick(100);
		check({7'h00, sckOe}, 8'h00);
		check({7'h00, sdoOe}, 8'h00);
		spi_far_model_i.drive(rx);
		tick(6);
		check(spi_far_model_i.got, tx);
		rd(`OFS_DATA, rx);
		tick(4);
		complete_run();
	end
endmodule
